// ==== sim/dlm_host_model.sv ====
/* host transmitter model: lane levels, serial data, burst-only link clock.
   assumes the bench calls send for one burst at a time. */
`timescale 1ns/100ps
`default_nettype none
`include "dlm_map.vh"
module dlm_host_model (
    input wire sys_clk, // bench clock, paces the link
    output logic link_clk, // link clock, still between bursts
    output logic [3:0] lane_hs, // lane in burst
    output logic [3:0] lane_dat // lane serial data
);
// ---------------------------------------------------------------
// burst sender
// ---------------------------------------------------------------
initial begin
    link_clk = 1'b0;
    lane_hs = 4'h0;
    lane_dat = 4'h5;
end
task send(input logic [7:0] q[$], input int nl);
    int i, j, b;
    logic [7:0] syn;
    syn = `DLM_SYNC_BYTE;
    @(posedge sys_clk);
    lane_hs <= 4'((1 << nl) - 1);
    repeat (4) @(posedge sys_clk);
    for (j = -1; j * nl < q.size(); j++) begin
        for (b = 0; b < 8; b++) begin
            for (i = 0; i < 4; i++) begin
                if (i < nl && (j < 0 || j * nl + i < q.size())) begin
                    // sync first, then bytes lsb first, round robin
                    lane_dat[i] <= (j < 0) ? syn[b] : q[j*nl+i][b];
                end else begin
                    lane_hs[i] <= 1'b0;
                    lane_dat[i] <= ~lane_dat[i];
                end
            end
            repeat (4) @(posedge sys_clk);
            link_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            link_clk <= 1'b0;
        end
    end
    lane_hs <= 4'h0;
    lane_dat <= ~lane_dat;
endtask
endmodule // dlm_host_model
`default_nettype wire

// ==== sim/dlm_lane_merge_asserts.sv ====
/* checker on the lane merger ports: lane state, output hold, burst end.
   assumes it is bound onto every dlm_lane_merge instance. */
`timescale 1ns/100ps
`default_nettype none
module dlm_lane_merge_asserts #(
    parameter LANES = 4
) (
    input wire sys_clk, // clock
    input wire rst, // reset
    input wire [LANES-1:0] lane_hs, // lane burst level
    input wire [1:0] cfg_lanes, // lanes minus one
    input wire cfg_eotp_en, // end packet check
    input wire out_ready, // sink ready
    input wire [7:0] out_data, // merged byte
    input wire out_sop, // packet start
    input wire out_valid, // byte valid
    input wire burst_end, // burst done
    input wire eotp_err, // end packet missing
    input wire [LANES-1:0] lane_lps // lane low power
);
// ---------------------------------------------------------------
// properties
// ---------------------------------------------------------------
wire [4:0] act_w = (5'h02 << cfg_lanes) - 5'h01;
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
sequence s_idle; (lane_hs == 0) [*4]; endsequence
sequence s_busy; lane_hs[0] [*4]; endsequence
sequence s_stall; out_valid && !out_ready; endsequence
chk_lps_reset: assert property ($fell(rst) |-> &lane_lps)
    else $error("lane not low power after reset");
chk_lps_idle: assert property (s_idle |=> &lane_lps)
    else $error("idle lane not low power");
chk_lps_busy: assert property (s_busy |=> !lane_lps[0])
    else $error("busy lane shown low power");
chk_hold_stall: assert property (s_stall |=> out_valid &&
    $stable(out_data) && $stable(out_sop))
    else $error("output changed while stalled");
chk_sop_valid: assert property (out_sop |-> out_valid)
    else $error("start flag without valid");
chk_err_end: assert property (eotp_err |-> burst_end)
    else $error("end packet error off burst end");
chk_err_off: assert property (!cfg_eotp_en |-> !eotp_err)
    else $error("end packet error while disabled");
chk_end_pulse: assert property (burst_end |=> !burst_end)
    else $error("burst end longer than a cycle");
chk_end_lanes: assert property (burst_end |->
    &(lane_lps | ~act_w[LANES-1:0]))
    else $error("burst end with active lane busy");
endmodule // dlm_lane_merge_asserts
bind dlm_lane_merge dlm_lane_merge_asserts #(.LANES(LANES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .lane_hs(lane_hs), .cfg_lanes(cfg_lanes),
    .cfg_eotp_en(cfg_eotp_en), .out_ready(out_ready), .out_data(out_data),
    .out_sop(out_sop), .out_valid(out_valid), .burst_end(burst_end),
    .eotp_err(eotp_err), .lane_lps(lane_lps));
`default_nettype wire

// ==== sim/testbench.sv ====
/* self-checking bench for the lane merger driven by the host model.
   assumes merger, checker and host model are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
logic sys_clk = 1'b0, rst = 1'b1, cfg_eotp_en = 1'b0, out_ready = 1'b1;
logic stall = 1'b0, block = 1'b0;
logic [1:0] cfg_lanes = 2'h0;
wire link_clk, out_sop, out_valid, burst_end, eotp_err, lane_overrun;
wire [3:0] lane_hs, lane_dat, lane_lps;
wire [7:0] out_data;
wire [1:0] pkt_vc;
wire [5:0] pkt_dt;
logic [8:0] rx[$];
logic [7:0] pk[$] = '{8'h69, 8'h01, 8'h00, 8'h06, 8'h01, 8'h0e, 8'h1e,
    8'h08, 8'h00, 8'h00, 8'h01};
int miscompares = 0, checked = 0, nend = 0, nerr = 0, nov = 0, cyc = 0;
// ---------------------------------------------------------------
// clock, instances, collector
// ---------------------------------------------------------------
always #4 sys_clk = ~sys_clk;
dlm_lane_merge u_dlm_lane_merge (.sys_clk(sys_clk), .rst(rst),
    .link_clk(link_clk), .lane_hs(lane_hs), .lane_dat(lane_dat),
    .cfg_lanes(cfg_lanes), .cfg_eotp_en(cfg_eotp_en), .out_ready(out_ready),
    .out_data(out_data), .out_sop(out_sop), .out_valid(out_valid),
    .pkt_vc(pkt_vc), .pkt_dt(pkt_dt), .burst_end(burst_end),
    .eotp_err(eotp_err), .lane_overrun(lane_overrun), .lane_lps(lane_lps));
dlm_host_model u_host (.sys_clk(sys_clk), .link_clk(link_clk), .lane_hs(lane_hs),
    .lane_dat(lane_dat));
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    out_ready <= !(stall && cyc[5]) && !block;
    if (!rst && out_valid && out_ready) rx.push_back({out_sop, out_data});
    nend <= nend + (!rst && burst_end);
    nerr <= nerr + (!rst && burst_end && eotp_err);
    nov <= nov + (!rst && lane_overrun);
end
task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
        miscompares++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task run(input logic [7:0] q[$], input int nl, input logic en, logic err);
    int k;
    @(posedge sys_clk);
    cfg_lanes <= 2'(nl - 1);
    cfg_eotp_en <= en;
    #1 rx = {};
    nend = 0;
    nerr = 0;
    nov = 0;
    u_host.send(q, nl);
    for (k = 0; k < 400 && nend == 0; k++) @(posedge sys_clk);
    // let a stalled output buffer drain before the byte count is judged
    repeat (40) @(posedge sys_clk);
    #1 chk(nend, 1);
    chk(nerr, err);
    chk(nov, 0);
    chk(rx.size(), q.size());
    for (k = 0; k < q.size() && k < rx.size(); k++)
        chk(rx[k], {k == 0 || k == 7, q[k]});
    chk({pkt_vc, pkt_dt}, q.size() > 7 ? q[7] : q[0]);
endtask
task t_lane_counts;
    int n;
    for (n = 1; n <= 4; n++) run(pk, n, 1'b1, 1'b0);
endtask
task t_eotp_missing;
    run(pk[0:6], 2, 1'b1, 1'b1);
    run(pk[0:6], 3, 1'b0, 1'b0);
endtask
task t_stall;
    stall = 1'b1;
    run(pk, 4, 1'b0, 1'b0);
    stall = 1'b0;
endtask
task t_overrun;
    int k;
    @(posedge sys_clk);
    cfg_lanes <= 2'h0;
    cfg_eotp_en <= 1'b0;
    block = 1'b1;
    #1 rx = {};
    nend = 0;
    nov = 0;
    u_host.send(pk, 1);
    block = 1'b0;
    for (k = 0; k < 400 && nend == 0; k++) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    // two buffer entries and the lane register survive, later bytes overrun
    #1 chk(nend, 1);
    chk(nov, pk.size() - 3);
    chk(rx.size(), 3);
    chk(rx[2], {1'b0, pk[10]});
endtask
task print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(lane_lps, 4'hf);
    t_lane_counts();
    t_eotp_missing();
    t_stall();
    t_overrun();
    print_verdict();
end
initial begin
    #300000;
    miscompares++;
    print_verdict();
end
endmodule // testbench
`default_nettype wire

// ==== verilog/dlm_lane_merge.v ====
/*
 * receive side lane merger: deserialises up to four data lanes sampled
 * against the shared link clock, merges bytes back into one stream, tracks
 * packet boundaries and checks the end-of-transmission packet.
 * assumes link clock, lane levels and lane data are asynchronous pins and
 * that link data is stable at each rising link clock edge.
 */
// Overview of operation
// - lane outside high-speed burst sits in low-power state; shown on lane_lps.
// - one to four lanes carry a single byte stream, chosen by cfg_lanes.
// - all lanes are sampled against one common link clock.
// - lanes start together; a lane may end one byte earlier.
// - merged stream restores the transmitter's exact byte order.
// - each burst opens with a sync sequence before any packet byte.
// - several packets per burst; burst ends with lane end-of-transmission.
// - end-of-transmission packet checking can be enabled or disabled.
// - bits on a lane arrive least significant first.
// - multi-byte fields arrive low-order byte first.
// - end-of-transmission packet uses data type 0x08.
// - short packet is four bytes: identifier, two data, ecc, no footer.
// - first packet byte holds channel in 7:6 and data type in 5:0.
// - after a packet ends, next byte is a new header or burst end.
`timescale 1ns/100ps
`default_nettype none
`include "dlm_map.vh"

module dlm_lane_merge #(
    parameter LANES = 4
) (
    input wire sys_clk, // system clock
    input wire rst, // synchronous reset, active high
    input wire link_clk, // shared link clock pin
    input wire [LANES-1:0] lane_hs, // lane in high-speed burst
    input wire [LANES-1:0] lane_dat, // lane serial data
    input wire [1:0] cfg_lanes, // active lanes minus one
    input wire cfg_eotp_en, // end packet checking enable
    input wire out_ready, // downstream can take a byte
    output reg [7:0] out_data, // merged byte
    output reg out_sop, // byte is the first of a packet
    output reg out_valid, // out_data holds a byte
    output reg [1:0] pkt_vc, // virtual channel of current packet
    output reg [5:0] pkt_dt, // data type of current packet
    output reg burst_end, // pulse: burst fully merged
    output reg eotp_err, // pulse: burst ended without end packet
    output reg lane_overrun, // pulse: lane byte lost
    output reg [LANES-1:0] lane_lps // lane in low-power state
);

// ---------------------------------------------------------------------------
// pin synchronisers and link clock edge
// ---------------------------------------------------------------------------
reg [2*LANES:0] meta;
reg [2*LANES:0] sync;
reg link_prev;
wire link_rise;
wire [LANES-1:0] hs_s;
wire [LANES-1:0] dat_s;
wire [LANES-1:0] act_mask;
wire burst_act;

always @(posedge sys_clk) begin
    if (rst) begin
        meta <= {(2*LANES+1){1'b0}};
        sync <= {(2*LANES+1){1'b0}};
        link_prev <= 1'b0;
        lane_lps <= {LANES{1'b1}};
    end else begin
        meta <= {link_clk, lane_hs, lane_dat};
        sync <= meta;
        link_prev <= sync[2*LANES];
        lane_lps <= ~sync[2*LANES-1:LANES];
    end
end

assign link_rise = sync[2*LANES] & ~link_prev;
assign hs_s = sync[2*LANES-1:LANES];
assign dat_s = sync[LANES-1:0];

genvar gi;
generate
    for (gi = 0; gi < LANES; gi = gi + 1) begin : g_mask
        assign act_mask[gi] = (gi <= cfg_lanes);
    end
endgenerate

assign burst_act = |(hs_s & act_mask);

// ---------------------------------------------------------------------------
// per lane deserialiser
// ---------------------------------------------------------------------------
wire [8*LANES-1:0] lane_byte;
wire [LANES-1:0] lane_full;
wire [LANES-1:0] lane_ovr;
reg [LANES-1:0] take;

generate
    for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
        reg [7:0] sh;
        reg [2:0] cnt;
        reg aligned;
        reg [7:0] hold;
        reg full;
        reg ovr;
        wire [7:0] next_sh;
        assign next_sh = {dat_s[gi], sh[7:1]};
        always @(posedge sys_clk) begin
            if (rst) begin
                sh <= 8'h00;
                cnt <= 3'h0;
                aligned <= 1'b0;
                hold <= 8'h00;
                full <= 1'b0;
                ovr <= 1'b0;
            end else begin
                ovr <= 1'b0;
                if (take[gi]) begin
                    full <= 1'b0;
                end
                if (!hs_s[gi] || !act_mask[gi]) begin
                    // low-power state drops alignment for the next burst
                    aligned <= 1'b0;
                    cnt <= 3'h0;
                    sh <= 8'h00;
                end else if (link_rise) begin
                    sh <= next_sh;
                    if (!aligned) begin
                        if (next_sh == `DLM_SYNC_BYTE) begin
                            aligned <= 1'b1;
                        end
                        cnt <= 3'h0;
                    end else begin
                        cnt <= cnt + 3'h1;
                        if (cnt == `DLM_BIT_LAST) begin
                            hold <= next_sh;
                            full <= 1'b1; // set wins over take
                            ovr <= full & ~take[gi];
                        end
                    end
                end
            end
        end
        assign lane_byte[8*gi+:8] = hold;
        assign lane_full[gi] = full;
        assign lane_ovr[gi] = ovr;
    end
endgenerate

// ---------------------------------------------------------------------------
// round-robin merge and packet tracking
// ---------------------------------------------------------------------------
reg [1:0] rr;
// one-hot packet position: identifier, word count low/high, ecc, body
localparam [4:0] ST_IDENT = 5'h01;
localparam [4:0] ST_WC_LO = 5'h02;
localparam [4:0] ST_WC_HI = 5'h04;
localparam [4:0] ST_ECC = 5'h08;
localparam [4:0] ST_BODY = 5'h10;
reg [4:0] hpos;
reg [16:0] rem;
reg [7:0] wc_lo;
reg is_long;
reg last_eotp;
reg seen;
reg sp_valid;
reg [8:0] sp_data;
reg [7:0] mbyte;
reg mfull;
reg push_sop;
wire push;
wire [8:0] push_data;

always @* begin
    take = {LANES{1'b0}};
    mbyte = lane_byte[8*rr+:8];
    mfull = lane_full[rr];
    take[rr] = mfull & ~sp_valid;
end

assign push = mfull & ~sp_valid;
always @* begin
    push_sop = (hpos == ST_IDENT);
end
assign push_data = {push_sop, mbyte};

always @(posedge sys_clk) begin
    if (rst) begin
        rr <= 2'h0;
        hpos <= ST_IDENT;
        rem <= 17'h00000;
        wc_lo <= 8'h00;
        is_long <= 1'b0;
        last_eotp <= 1'b0;
        seen <= 1'b0;
        pkt_vc <= 2'h0;
        pkt_dt <= 6'h00;
        burst_end <= 1'b0;
        eotp_err <= 1'b0;
        lane_overrun <= 1'b0;
    end else begin
        burst_end <= 1'b0;
        eotp_err <= 1'b0;
        lane_overrun <= |lane_ovr;
        if (push) begin
            seen <= 1'b1;
            rr <= (rr == cfg_lanes) ? 2'h0 : rr + 2'h1;
            case (hpos)
                ST_IDENT: begin
                    pkt_vc <= mbyte[`DLM_VC_MSB:`DLM_VC_LSB];
                    pkt_dt <= mbyte[`DLM_DT_MSB:`DLM_DT_LSB];
                    is_long <= (mbyte[3:0] == `DLM_DT_LONG_A) ||
                        (mbyte[3:0] == `DLM_DT_LONG_B);
                    last_eotp <= (mbyte[`DLM_DT_MSB:`DLM_DT_LSB] ==
                        `DLM_DT_EOTP);
                    hpos <= ST_WC_LO;
                end
                ST_WC_LO: begin
                    wc_lo <= mbyte;
                    hpos <= ST_WC_HI;
                end
                ST_WC_HI: begin
                    rem <= {1'b0, mbyte, wc_lo} + `DLM_FOOTER_LEN;
                    hpos <= ST_ECC;
                end
                ST_ECC: begin
                    // short packets end at the ecc byte
                    hpos <= is_long ? ST_BODY : ST_IDENT;
                end
                ST_BODY: begin
                    rem <= rem - 17'h00001;
                    if (rem == 17'h00001) begin
                        hpos <= ST_IDENT;
                    end
                end
                default: begin
                    hpos <= ST_IDENT;
                end
            endcase
        end else if (!burst_act && !(|lane_full) && seen) begin
            // all active lanes back in low-power state and drained
            seen <= 1'b0;
            rr <= 2'h0;
            hpos <= ST_IDENT;
            burst_end <= 1'b1;
            eotp_err <= cfg_eotp_en &
                (~last_eotp | (hpos != ST_IDENT));
            last_eotp <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------------------
// two-entry output buffer
// ---------------------------------------------------------------------------
always @(posedge sys_clk) begin
    if (rst) begin
        out_valid <= 1'b0;
        out_data <= 8'h00;
        out_sop <= 1'b0;
        sp_valid <= 1'b0;
        sp_data <= 9'h000;
    end else if (out_ready || !out_valid) begin
        if (sp_valid) begin
            {out_sop, out_data} <= sp_data;
            out_valid <= 1'b1;
            sp_valid <= 1'b0;
        end else if (push) begin
            {out_sop, out_data} <= push_data;
            out_valid <= 1'b1;
        end else begin
            out_valid <= 1'b0;
            out_sop <= 1'b0;
        end
    end else if (push) begin
        sp_data <= push_data;
        sp_valid <= 1'b1;
    end
end

endmodule // dlm_lane_merge

`default_nettype wire

// ==== verilog/dlm_map.vh ====
/*
 * constants for the lane merging receiver: sync pattern, packet layout and
 * data type codes.
 * assumes inclusion by bare name from the design file.
 */
`ifndef DLM_MAP_VH
`define DLM_MAP_VH

// ---------------------------------------------------------------------------
// link framing
// ---------------------------------------------------------------------------
`define DLM_SYNC_BYTE 8'hb8
`define DLM_BIT_LAST 3'h7

// ---------------------------------------------------------------------------
// packet layout
// ---------------------------------------------------------------------------
`define DLM_FOOTER_LEN 17'h00002
`define DLM_VC_MSB 7
`define DLM_VC_LSB 6
`define DLM_DT_MSB 5
`define DLM_DT_LSB 0

// ---------------------------------------------------------------------------
// data types
// ---------------------------------------------------------------------------
`define DLM_DT_EOTP 6'h08
`define DLM_DT_LONG_A 4'h9
`define DLM_DT_LONG_B 4'he

`endif
